// ---- hdl/wts_sequencer.v ----
// waveform task sequencer: task and scenario tables, trigger handling, wishbone slave
`timescale 1ns/1ps
`include "wts_defs.vh"

module wts_sequencer #(
  parameter TASK_AW = 16,
  parameter SCN_AW  = 10,
  parameter DAC_W   = 16
) (
  input  wire               clk_i,
  input  wire               rst_i,
  input  wire [7:0]         wb_adr_i,
  input  wire [31:0]        wb_dat_i,
  output reg  [31:0]        wb_dat_o,
  input  wire [3:0]         wb_sel_i,
  input  wire               wb_we_i,
  input  wire               wb_cyc_i,
  input  wire               wb_stb_i,
  output wire               wb_ack_o,
  input  wire               ext_trig_a_i,
  input  wire               ext_trig_b_i,
  input  wire               int_trig_i,
  input  wire               hw_trig_i,
  input  wire               fb_trig_i,
  input  wire [15:0]        fb_task_i,
  input  wire               seg_end_i,
  output reg  [15:0]        seg_sel_o,
  output reg                play_o,
  output reg                idle_o,
  output reg  [1:0]         idle_mode_o,
  output reg  [DAC_W-1:0]   idle_level_o,
  output reg                active_o
);

  localparam [5:0] S_STOP  = 6'h01;
  localparam [5:0] S_LOAD  = 6'h02;
  localparam [5:0] S_DELAY = 6'h04;
  localparam [5:0] S_WAIT  = 6'h08;
  localparam [5:0] S_PLAY  = 6'h10;
  localparam [5:0] S_SCN   = 6'h20;

  ////////////////////////////////////////////////////////////////////////
  // tables
  reg [`WTS_ENTRY_W-1:0] task_mem [0:(1<<TASK_AW)-1];
  reg [36:0]             scn_mem  [0:(1<<SCN_AW)-1];

  reg [31:0]        stage_reg [0:5];
  reg [15:0]        scn_ptr_reg;
  reg [20:0]        scn_rep_reg;
  reg [SCN_AW:0]    scn_count_reg;
  reg               run_reg;
  reg               run_d_reg;
  reg               swtrig_reg;
  reg               ack_reg;

  reg [5:0]         state_reg;
  reg [TASK_AW-1:0] task_reg;
  reg [`WTS_ENTRY_W-1:0] ent_reg;
  reg [20:0]        loop_reg;
  reg [31:0]        delay_reg;
  reg               armed_reg;
  reg               abort_pend_reg;
  reg               branch_b_reg;
  reg               branch_set_reg;
  reg [15:0]        fb_task_reg;
  reg [TASK_AW-1:0] grp_start_reg;
  reg [20:0]        grp_loops_reg;
  reg [20:0]        grp_cnt_reg;
  reg [SCN_AW-1:0]  scn_idx_reg;
  reg [20:0]        scn_cnt_reg;

  reg [2:0]         ext_a_sync_reg;
  reg [2:0]         ext_b_sync_reg;
  wire              ext_a_evt = ext_a_sync_reg[1] & ~ext_a_sync_reg[2];
  wire              ext_b_evt = ext_b_sync_reg[1] & ~ext_b_sync_reg[2];

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // one decoder serves both the enabling and the aborting selector
  function src_evt;
    input [2:0] src;
    input       a;
    input       b;
    input       it;
    input       sw;
    input       fb;
    input       hw;
    begin
      case (src)
        `WTS_SRC_EXT_A:  src_evt = a;
        `WTS_SRC_EXT_B:  src_evt = b;
        `WTS_SRC_INT:    src_evt = it;
        `WTS_SRC_SW:     src_evt = sw;
        `WTS_SRC_FB:     src_evt = fb;
        `WTS_SRC_HW:     src_evt = hw;
        `WTS_SRC_EITHER: src_evt = a | b;
        default:         src_evt = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state; a write lands on the edge at which the master sees ack high
  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
  assign wb_ack_o = ack_reg;

  integer k;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg       <= 1'b0;
      run_reg       <= 1'b0;
      swtrig_reg    <= 1'b0;
      scn_count_reg <= {(SCN_AW+1){1'b0}};
      scn_ptr_reg   <= 16'h0000;
      scn_rep_reg   <= 21'h000000;
      for (k = 0; k < 6; k = k + 1) begin
        stage_reg[k] <= `WTS_RST_WORD;
      end
    end else begin
      ack_reg    <= wb_req;
      swtrig_reg <= 1'b0;
      if (wb_wr) begin
        case (wb_adr_i)
          `WTS_REG_CTRL: begin
            if (wb_sel_i[0]) begin
              run_reg    <= wb_dat_i[`WTS_CTRL_RUN];
              swtrig_reg <= wb_dat_i[`WTS_CTRL_SWTRIG];
            end
          end
          `WTS_REG_SCN_COUNT: scn_count_reg <= wb_dat_i[SCN_AW:0];
          `WTS_REG_STAGE0:    stage_reg[0] <= merge(stage_reg[0], wb_dat_i, wb_sel_i);
          `WTS_REG_STAGE1:    stage_reg[1] <= merge(stage_reg[1], wb_dat_i, wb_sel_i);
          `WTS_REG_STAGE2:    stage_reg[2] <= merge(stage_reg[2], wb_dat_i, wb_sel_i);
          `WTS_REG_STAGE3:    stage_reg[3] <= merge(stage_reg[3], wb_dat_i, wb_sel_i);
          `WTS_REG_STAGE4:    stage_reg[4] <= merge(stage_reg[4], wb_dat_i, wb_sel_i);
          `WTS_REG_STAGE5:    stage_reg[5] <= merge(stage_reg[5], wb_dat_i, wb_sel_i);
          `WTS_REG_SCN_PTR:   scn_ptr_reg <= wb_dat_i[15:0];
          `WTS_REG_SCN_REP:   scn_rep_reg <= wb_dat_i[20:0];
          default: ;
        endcase
      end
    end
  end

  // table commits: writing an index copies the staged entry into the table
  always @(posedge clk_i) begin
    if (wb_wr && wb_adr_i == `WTS_REG_TASK_WR) begin
      task_mem[wb_dat_i[TASK_AW-1:0]] <= {stage_reg[5], stage_reg[4], stage_reg[3],
                                          stage_reg[2], stage_reg[1], stage_reg[0]};
    end
    if (wb_wr && wb_adr_i == `WTS_REG_SCN_WR) begin
      scn_mem[wb_dat_i[SCN_AW-1:0]] <= {scn_rep_reg, scn_ptr_reg};
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      case (wb_adr_i)
        `WTS_REG_CTRL:      wb_dat_o <= {31'h0000_0000, run_reg};
        `WTS_REG_STATUS:    wb_dat_o <= {26'h000_0000, state_reg};
        `WTS_REG_CUR_TASK:  wb_dat_o <= {{(32-TASK_AW){1'b0}}, task_reg};
        `WTS_REG_SCN_COUNT: wb_dat_o <= {{(31-SCN_AW){1'b0}}, scn_count_reg};
        `WTS_REG_LOOP_CNT:  wb_dat_o <= {11'h000, loop_reg};
        `WTS_REG_STAGE0:    wb_dat_o <= stage_reg[0];
        `WTS_REG_STAGE1:    wb_dat_o <= stage_reg[1];
        `WTS_REG_STAGE2:    wb_dat_o <= stage_reg[2];
        `WTS_REG_STAGE3:    wb_dat_o <= stage_reg[3];
        `WTS_REG_STAGE4:    wb_dat_o <= stage_reg[4];
        `WTS_REG_STAGE5:    wb_dat_o <= stage_reg[5];
        `WTS_REG_SCN_PTR:   wb_dat_o <= {16'h0000, scn_ptr_reg};
        `WTS_REG_SCN_REP:   wb_dat_o <= {11'h000, scn_rep_reg};
        default:            wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger front end; external pins are asynchronous
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_a_sync_reg <= 3'h0;
      ext_b_sync_reg <= 3'h0;
    end else begin
      ext_a_sync_reg <= {ext_a_sync_reg[1:0], ext_trig_a_i};
      ext_b_sync_reg <= {ext_b_sync_reg[1:0], ext_trig_b_i};
    end
  end

  wire en_evt = src_evt(ent_reg[`WTS_F_EN], ext_a_evt, ext_b_evt, int_trig_i,
                        swtrig_reg, fb_trig_i, hw_trig_i);
  wire ab_evt = src_evt(ent_reg[`WTS_F_AB], ext_a_evt, ext_b_evt, int_trig_i,
                        swtrig_reg, fb_trig_i, 1'b0);
  wire has_en   = ent_reg[`WTS_F_EN] != `WTS_SRC_NONE;
  wire has_ab   = ent_reg[`WTS_F_AB] != `WTS_SRC_NONE;
  wire [20:0] loops = ent_reg[`WTS_F_LOOPS];
  wire last_loop    = (loops != 21'h000000) && (loop_reg + 21'h000001 >= loops);
  wire aborting     = ab_evt | abort_pend_reg;
  // an immediate jump leaves on the abort edge itself, so latency never varies
  wire end_now  = has_ab & ~ent_reg[`WTS_F_JMODE] & ab_evt;
  wire end_loop = seg_end_i & (has_ab ? (aborting | last_loop) : last_loop);
  wire grp_again = (ent_reg[`WTS_F_TYPE] == `WTS_TYPE_GEND) &&
                   ((grp_loops_reg == 21'h000000) ||
                    (grp_cnt_reg + 21'h000001 < grp_loops_reg));

  // jump destination of the ending task
  reg [TASK_AW-1:0] dest_task;
  always @* begin
    case (ent_reg[`WTS_F_DEST])
      `WTS_DEST_FB:     dest_task = fb_trig_i ? fb_task_i[TASK_AW-1:0] : fb_task_reg[TASK_AW-1:0];
      `WTS_DEST_BRANCH: dest_task = (branch_set_reg ? branch_b_reg : (ext_b_evt & ~ext_a_evt)) ?
                                    ent_reg[`WTS_F_NEXT2] : ent_reg[`WTS_F_NEXT1];
      default:          dest_task = ent_reg[`WTS_F_NEXT1];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  wire [36:0] scn_ent  = scn_mem[scn_idx_reg];
  wire        scn_used = scn_count_reg != {(SCN_AW+1){1'b0}};
  wire        task_end = end_now | end_loop;

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg      <= S_STOP;
      run_d_reg      <= 1'b0;
      task_reg       <= `WTS_DEFAULT_TASK;
      ent_reg        <= {`WTS_ENTRY_W{1'b0}};
      loop_reg       <= 21'h000000;
      delay_reg      <= 32'h0000_0000;
      armed_reg      <= 1'b0;
      abort_pend_reg <= 1'b0;
      branch_b_reg   <= 1'b0;
      branch_set_reg <= 1'b0;
      fb_task_reg    <= 16'h0000;
      grp_start_reg  <= {TASK_AW{1'b0}};
      grp_loops_reg  <= 21'h000000;
      grp_cnt_reg    <= 21'h000000;
      scn_idx_reg    <= {SCN_AW{1'b0}};
      scn_cnt_reg    <= 21'h000000;
    end else begin
      run_d_reg <= run_reg;
      if (fb_trig_i) begin
        fb_task_reg <= fb_task_i;
      end
      if (!run_reg) begin
        state_reg <= S_STOP;
      end else begin
        case (state_reg)
          S_STOP: begin
            if (!run_d_reg) begin
              scn_idx_reg <= {SCN_AW{1'b0}};
              scn_cnt_reg <= 21'h000000;
              grp_cnt_reg <= 21'h000000;
              if (scn_used) begin
                task_reg <= scn_mem[{SCN_AW{1'b0}}][TASK_AW-1:0];
              end else begin
                task_reg <= `WTS_DEFAULT_TASK;
              end
              state_reg <= S_LOAD;
            end
          end
          S_LOAD: begin
            ent_reg        <= task_mem[task_reg];
            loop_reg       <= 21'h000000;
            delay_reg      <= task_mem[task_reg][`WTS_F_DELAY];
            armed_reg      <= 1'b0;
            abort_pend_reg <= 1'b0;
            branch_set_reg <= 1'b0;
            branch_b_reg   <= 1'b0;
            if (task_mem[task_reg][`WTS_F_TYPE] == `WTS_TYPE_GSTART &&
                grp_start_reg != task_reg) begin
              grp_start_reg <= task_reg;
              grp_loops_reg <= task_mem[task_reg][`WTS_F_GLOOPS];
              grp_cnt_reg   <= 21'h000000;
            end
            state_reg <= S_DELAY;
          end
          S_DELAY: begin
            if (delay_reg != 32'h0000_0000) begin
              delay_reg <= delay_reg - 32'h0000_0001;
            end else if (has_en) begin
              state_reg <= S_WAIT;
            end else begin
              state_reg <= S_PLAY;
            end
          end
          S_WAIT: begin
            if (en_evt) begin
              state_reg <= S_PLAY;
            end
          end
          S_PLAY: begin
            if (ab_evt) begin
              abort_pend_reg <= 1'b1;
            end
            if (!branch_set_reg && (ext_a_evt || ext_b_evt)) begin
              branch_set_reg <= 1'b1;
              branch_b_reg   <= ~ext_a_evt;
            end
            if (task_end) begin
              if (grp_again) begin
                grp_cnt_reg <= grp_cnt_reg + 21'h000001;
                task_reg    <= grp_start_reg;
                state_reg   <= S_LOAD;
              end else begin
                if (ent_reg[`WTS_F_TYPE] == `WTS_TYPE_GEND) begin
                  grp_start_reg <= ~task_reg;
                end
                if (ent_reg[`WTS_F_DEST] == `WTS_DEST_SCN) begin
                  state_reg <= S_SCN;
                end else begin
                  task_reg  <= dest_task;
                  state_reg <= S_LOAD;
                end
              end
            end else if (seg_end_i) begin
              loop_reg <= loop_reg + 21'h000001;
              // a looping task without per-loop triggering keeps one enable
              if (has_en && ent_reg[`WTS_F_PERLOOP] && loops != 21'h000001) begin
                state_reg <= S_WAIT;
              end
            end
          end
          S_SCN: begin
            if (!scn_used) begin
              task_reg <= `WTS_DEFAULT_TASK;
            end else if (scn_ent[36:16] == 21'h000000 ||
                         scn_cnt_reg + 21'h000001 < scn_ent[36:16]) begin
              scn_cnt_reg <= scn_cnt_reg + 21'h000001;
              task_reg    <= scn_ent[TASK_AW-1:0];
            end else begin
              scn_cnt_reg <= 21'h000000;
              if ({1'b0, scn_idx_reg} + {{SCN_AW{1'b0}}, 1'b1} >= scn_count_reg) begin
                scn_idx_reg <= {SCN_AW{1'b0}};
                task_reg    <= scn_mem[{SCN_AW{1'b0}}][TASK_AW-1:0];
              end else begin
                scn_idx_reg <= scn_idx_reg + {{(SCN_AW-1){1'b0}}, 1'b1};
                task_reg    <= scn_mem[scn_idx_reg + {{(SCN_AW-1){1'b0}}, 1'b1}][TASK_AW-1:0];
              end
            end
            state_reg <= S_LOAD;
          end
          default: state_reg <= S_STOP;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output toward the dac sample path
  wire idle_now = (state_reg == S_DELAY) || (state_reg == S_WAIT);
  always @(posedge clk_i) begin
    if (rst_i) begin
      seg_sel_o    <= 16'h0000;
      play_o       <= 1'b0;
      idle_o       <= 1'b0;
      idle_mode_o  <= `WTS_IDLE_DC;
      idle_level_o <= {DAC_W{1'b0}};
      active_o     <= 1'b0;
    end else begin
      seg_sel_o    <= ent_reg[`WTS_F_SEG];
      idle_o       <= idle_now;
      idle_mode_o  <= ent_reg[`WTS_F_IDLE];
      idle_level_o <= ent_reg[16 +: DAC_W];
      play_o       <= (state_reg == S_PLAY) ||
                      (idle_now && ent_reg[`WTS_F_IDLE] == `WTS_IDLE_PLAY);
      active_o     <= state_reg != S_STOP;
    end
  end

endmodule // wts_sequencer

// ---- hdl/wts_defs.vh ----
// register map, table field layout, codes and reset values of the waveform task sequencer
`ifndef WTS_DEFS_VH
`define WTS_DEFS_VH

// register byte offsets
`define WTS_REG_CTRL      8'h00
`define WTS_REG_STATUS    8'h04
`define WTS_REG_CUR_TASK  8'h08
`define WTS_REG_SCN_COUNT 8'h0c
`define WTS_REG_TASK_WR   8'h10
`define WTS_REG_SCN_WR    8'h14
`define WTS_REG_LOOP_CNT  8'h18
`define WTS_REG_STAGE0    8'h20
`define WTS_REG_STAGE1    8'h24
`define WTS_REG_STAGE2    8'h28
`define WTS_REG_STAGE3    8'h2c
`define WTS_REG_STAGE4    8'h30
`define WTS_REG_STAGE5    8'h34
`define WTS_REG_SCN_PTR   8'h38
`define WTS_REG_SCN_REP   8'h3c

// control bits
`define WTS_CTRL_RUN      0
`define WTS_CTRL_SWTRIG   1

// task entry: 192 bits, stage word n sits at bits 32n+31:32n
`define WTS_F_TYPE        1:0
`define WTS_F_IDLE        3:2
`define WTS_F_EN          6:4
`define WTS_F_AB          9:7
`define WTS_F_JMODE       10
`define WTS_F_DEST        12:11
`define WTS_F_PERLOOP     13
`define WTS_F_DC          31:16
`define WTS_F_LOOPS       52:32
`define WTS_F_GLOOPS      84:64
`define WTS_F_SEG         111:96
`define WTS_F_NEXT1       143:128
`define WTS_F_NEXT2       159:144
`define WTS_F_DELAY       191:160
`define WTS_ENTRY_W       192

// task types
`define WTS_TYPE_SINGLE   2'h0
`define WTS_TYPE_GSTART   2'h1
`define WTS_TYPE_GMIDDLE  2'h2
`define WTS_TYPE_GEND     2'h3

// idle modes
`define WTS_IDLE_DC       2'h0
`define WTS_IDLE_FIRST    2'h1
`define WTS_IDLE_PLAY     2'h2

// trigger sources (enabling and aborting share the coding)
`define WTS_SRC_NONE      3'h0
`define WTS_SRC_EXT_A     3'h1
`define WTS_SRC_EXT_B     3'h2
`define WTS_SRC_INT       3'h3
`define WTS_SRC_SW        3'h4
`define WTS_SRC_FB        3'h5
`define WTS_SRC_HW        3'h6
`define WTS_SRC_EITHER    3'h7

// jump destinations
`define WTS_DEST_NEXT1    2'h0
`define WTS_DEST_FB       2'h1
`define WTS_DEST_BRANCH   2'h2
`define WTS_DEST_SCN      2'h3

// reset values
`define WTS_DEFAULT_TASK  16'h0001
`define WTS_RST_WORD      32'h0000_0000

`endif

// ---- testbench/wts_properties.sv ----
// concurrent checks on the ports of the waveform task sequencer
`timescale 1ns/1ps
module wts_checker #(
  parameter DAC_W = 16
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_ack_o,
  input wire logic [15:0]      seg_sel_o,
  input wire logic             play_o,
  input wire logic             idle_o,
  input wire logic [1:0]       idle_mode_o,
  input wire logic [DAC_W-1:0] idle_level_o,
  input wire logic             active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack_once; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence s_out_up; ##[1:4] (play_o || idle_o); endsequence
  property p_ack_follows; s_req |=> s_ack_once; endproperty
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  // outputs come from the reset edge, so they must read zero right after release
  property p_reset_quiet; $fell(rst_i) |-> !active_o && !play_o && !idle_o && !wb_ack_o; endproperty
  property p_play_active; play_o |-> active_o; endproperty
  property p_idle_excl; idle_o |-> active_o && (!play_o || idle_mode_o == 2'h2); endproperty
  property p_seg_stable; play_o && $past(play_o) |-> $stable(seg_sel_o); endproperty
  property p_level_stable; idle_o && $past(idle_o) |-> $stable(idle_level_o) && $stable(idle_mode_o); endproperty
  property p_start; $rose(active_o) |-> s_out_up; endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack missing after request");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  a_play_active: assert property (p_play_active) else $error("playing while stopped");
  a_idle_excl: assert property (p_idle_excl) else $error("idle and play together");
  a_seg_stable: assert property (p_seg_stable) else $error("segment changed mid play");
  a_level_stable: assert property (p_level_stable) else $error("idle level moved");
  a_start: assert property (p_start) else $error("no output after start");
endmodule // wts_checker

// ---- testbench/wts_far_model.sv ----
// trigger sources and sample path on the far side of the sequencer
`timescale 1ns/1ps
`include "wts_defs.vh"
module wts_far_model #(
  parameter SEG_LEN = 8
) (
  input  wire logic        clk_i,
  input  wire logic        play_i,
  output logic             seg_end_o,
  output logic             ext_a_o = 1'b0,
  output logic             ext_b_o = 1'b0,
  output logic             int_o = 1'b0,
  output logic             hw_o = 1'b0,
  output logic             fb_o = 1'b0,
  output logic [15:0]      fb_task_o = 16'h0
);
  int cnt = 0;
  // last sample of every loop while the segment streams
  always @(posedge clk_i) cnt <= (!play_i || cnt == SEG_LEN - 1) ? 0 : cnt + 1;
  assign seg_end_o = play_i && (cnt == SEG_LEN - 1);
  // one-cycle pulse; callers fire well clear of a segment end
  task fire(input [2:0] k, input [15:0] t);
    @(posedge clk_i);
    fb_task_o <= t;
    ext_a_o <= (k == `WTS_SRC_EXT_A);
    ext_b_o <= (k == `WTS_SRC_EXT_B);
    fb_o <= (k == `WTS_SRC_FB);
    @(posedge clk_i);
    {ext_a_o, ext_b_o, fb_o} <= 3'h0;
  endtask
endmodule // wts_far_model

// ---- testbench/waveform_task_sequencer_bench.sv ----
// self-checking bench of the waveform task sequencer
`timescale 1ns/1ps
`include "wts_defs.vh"
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin n_errors++; $display("BAD %0t %s", $time, m); end end
module waveform_task_sequencer_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o, ok;
  logic        ext_a, ext_b, int_t, hw_t, fb_t, seg_end_i, play_o, idle_o, active_o;
  logic [15:0] fb_task, seg_sel_o, idle_level_o;
  logic [1:0]  idle_mode_o;
  int          n_errors = 0, checked = 0, cycles = 0;
  always #12.5 clk_i = ~clk_i;
  wts_sequencer #(.DAC_W(16)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_sel_i(4'hf), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .ext_trig_a_i(ext_a), .ext_trig_b_i(ext_b), .int_trig_i(int_t), .hw_trig_i(hw_t), .fb_trig_i(fb_t),
    .fb_task_i(fb_task), .seg_end_i(seg_end_i), .seg_sel_o(seg_sel_o), .play_o(play_o), .idle_o(idle_o),
    .idle_mode_o(idle_mode_o), .idle_level_o(idle_level_o), .active_o(active_o));
  wts_far_model #(.SEG_LEN(8)) i_far (
    .clk_i(clk_i), .play_i(play_o), .seg_end_o(seg_end_i), .ext_a_o(ext_a), .ext_b_o(ext_b),
    .int_o(int_t), .hw_o(hw_t), .fb_o(fb_t), .fb_task_o(fb_task));
  ////////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_errors++;
      wrap_up();
    end
  end
  // ack is judged at the rising edge; the request is released on that same edge
  task wb(input [7:0] a, input [31:0] d, input w);
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i <= w;
    {wb_cyc_i, wb_stb_i} <= 2'h3;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  function automatic [191:0] ent(input [15:0] seg, input [20:0] loops, input [15:0] n1, n2,
                                 input [2:0] en, ab, input [1:0] dest, input [31:0] dly, input [15:0] dc);
    ent = 192'h0;
    ent[`WTS_F_SEG] = seg;
    ent[`WTS_F_LOOPS] = loops;
    ent[`WTS_F_NEXT1] = n1;
    ent[`WTS_F_NEXT2] = n2;
    ent[`WTS_F_EN] = en;
    ent[`WTS_F_AB] = ab;
    ent[`WTS_F_DEST] = dest;
    ent[`WTS_F_DELAY] = dly;
    ent[`WTS_F_DC] = dc;
  endfunction
  task put(input [15:0] i, input [191:0] e);
    for (int k = 0; k < 6; k++) wb(8'h20 + 8'(4 * k), e[32 * k +: 32], 1'b1);
    wb(`WTS_REG_TASK_WR, {16'h0, i}, 1'b1);
  endtask
  task wait_play(input [15:0] s, input int lim, output logic f);
    int n;
    n = 0;
    while (!(seg_sel_o === s && play_o === 1'b1) && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    f = (n < lim);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_loops;
    int e;
    e = 0;
    wb(`WTS_REG_STATUS, 32'h0, 1'b0);
    `CHK(rd, 32'h1, "status after reset")
    wb(`WTS_REG_CTRL, 32'h1, 1'b1);
    wait_play(16'h5, 20, ok);
    `CHK(ok, 1'b1, "default task not started")
    while (seg_sel_o === 16'h5 && e < 9) begin
      @(negedge clk_i);
      if (seg_end_i === 1'b1) e++;
    end
    `CHK(e, 2, "loop count")
    `CHK(seg_sel_o, 16'h9, "next task segment")
    $display("t_loops done");
  endtask
  task t_delay;
    int n;
    n = 0;
    while (play_o !== 1'b1 && n < 50) begin
      @(negedge clk_i);
      if (idle_o === 1'b1) n++;
      if (idle_o === 1'b1) `CHK({idle_mode_o, idle_level_o}, {`WTS_IDLE_DC, 16'h1234}, "idle dc")
    end
    `CHK(n >= 10 && n <= 12, 1'b1, "delay length")
    $display("t_delay done");
  endtask
  task t_enable;
    logic early;
    early = 1'b0;
    while (seg_sel_o !== 16'h3) @(negedge clk_i);
    repeat (20) begin
      @(negedge clk_i);
      if (play_o !== 1'b0) early = 1'b1;
    end
    `CHK(early, 1'b0, "played before enable")
    i_far.fire(`WTS_SRC_EXT_A, 16'h0);
    wait_play(16'h3, 10, ok);
    `CHK(ok, 1'b1, "no start on enable")
    repeat (24) @(negedge clk_i);
    `CHK(seg_sel_o, 16'h3, "endless task ended")
    wb(`WTS_REG_CTRL, 32'h3, 1'b1);
    wait_play(16'h4, 12, ok);
    `CHK(ok, 1'b1, "software abort")
    $display("t_enable done");
  endtask
  task t_jumps;
    i_far.fire(`WTS_SRC_FB, 16'h5);
    wait_play(16'h55, 12, ok);
    `CHK(ok, 1'b1, "feedback destination")
    wait_play(16'h66, 40, ok);
    `CHK(ok, 1'b1, "plain target chain")
    i_far.fire(`WTS_SRC_EXT_B, 16'h0);
    wait_play(16'h77, 12, ok);
    `CHK(ok, 1'b1, "second branch")
    wb(`WTS_REG_CUR_TASK, 32'h0, 1'b0);
    `CHK(rd, 32'h7, "current task")
    wb(8'hfc, 32'h0, 1'b0);
    `CHK(rd, 32'h0, "unmapped read")
    wb(`WTS_REG_CTRL, 32'h0, 1'b1);
    repeat (3) @(negedge clk_i);
    `CHK({active_o, play_o}, 2'h0, "stop")
    $display("t_jumps done");
  endtask
  task t_group;
    logic [191:0] e;
    logic [143:0] got;
    logic         was;
    int           n;
    got = 144'h0;
    was = 1'b0;
    n = 0;
    e = ent(16'h88, 21'h1, 16'h9, 16'h0, `WTS_SRC_NONE, `WTS_SRC_NONE, `WTS_DEST_NEXT1, 32'h0, 16'h0);
    e[`WTS_F_TYPE] = `WTS_TYPE_GSTART;
    e[`WTS_F_GLOOPS] = 21'h2;
    put(16'h8, e);
    // group loops in the end entry must be ignored
    e = ent(16'h99, 21'h1, 16'h0, 16'h0, `WTS_SRC_NONE, `WTS_SRC_NONE, `WTS_DEST_SCN, 32'h0, 16'h0);
    e[`WTS_F_TYPE] = `WTS_TYPE_GEND;
    e[`WTS_F_GLOOPS] = 21'h5;
    put(16'h9, e);
    put(16'ha, ent(16'haa, 21'h1, 16'h0, 16'h0, `WTS_SRC_NONE, `WTS_SRC_NONE, `WTS_DEST_SCN, 32'h0, 16'h0));
    wb(`WTS_REG_SCN_PTR, 32'h8, 1'b1);
    wb(`WTS_REG_SCN_REP, 32'h2, 1'b1);
    wb(`WTS_REG_SCN_WR, 32'h0, 1'b1);
    wb(`WTS_REG_SCN_PTR, 32'ha, 1'b1);
    wb(`WTS_REG_SCN_REP, 32'h1, 1'b1);
    wb(`WTS_REG_SCN_WR, 32'h1, 1'b1);
    wb(`WTS_REG_SCN_COUNT, 32'h2, 1'b1);
    wb(`WTS_REG_CTRL, 32'h1, 1'b1);
    repeat (200) begin
      @(negedge clk_i);
      if (play_o === 1'b1 && !was && n < 9) begin
        got = {got[127:0], seg_sel_o};
        n++;
      end
      was = (play_o === 1'b1);
    end
    `CHK(got, 144'h0088_0099_0088_0099_0088_0099_0088_0099_00aa, "group and scenario order")
    wb(`WTS_REG_CTRL, 32'h0, 1'b1);
    $display("t_group done");
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    put(16'h1, ent(16'h5, 21'h2, 16'h2, 16'h0, `WTS_SRC_NONE, `WTS_SRC_NONE, `WTS_DEST_NEXT1, 32'h0, 16'h0));
    put(16'h2, ent(16'h9, 21'h1, 16'h3, 16'h0, `WTS_SRC_NONE, `WTS_SRC_NONE, `WTS_DEST_NEXT1, 32'ha, 16'h1234));
    put(16'h3, ent(16'h3, 21'h0, 16'h4, 16'h0, `WTS_SRC_EXT_A, `WTS_SRC_SW, `WTS_DEST_NEXT1, 32'h0, 16'h0));
    put(16'h4, ent(16'h4, 21'h0, 16'h0, 16'h0, `WTS_SRC_NONE, `WTS_SRC_FB, `WTS_DEST_FB, 32'h0, 16'h0));
    // the feedback target 5 and the branch target 7 are plain one-loop tasks; task 6 plays until aborted
    put(16'h5, ent(16'h55, 21'h1, 16'h6, 16'h0, `WTS_SRC_NONE, `WTS_SRC_NONE, `WTS_DEST_NEXT1, 32'h0, 16'h0));
    put(16'h6, ent(16'h66, 21'h0, 16'h2, 16'h7, `WTS_SRC_NONE, `WTS_SRC_EITHER, `WTS_DEST_BRANCH, 32'h0, 16'h0));
    put(16'h7, ent(16'h77, 21'h1, 16'h7, 16'h0, `WTS_SRC_NONE, `WTS_SRC_NONE, `WTS_DEST_NEXT1, 32'h0, 16'h0));
    t_loops();
    t_delay();
    t_enable();
    t_jumps();
    t_group();
    wrap_up();
  end
endmodule // waveform_task_sequencer_bench
bind wts_sequencer wts_checker #(.DAC_W(DAC_W)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .seg_sel_o(seg_sel_o), .play_o(play_o), .idle_o(idle_o), .idle_mode_o(idle_mode_o),
  .idle_level_o(idle_level_o), .active_o(active_o));
